// *** core/aes_pkg.sv ***
// Shared constants, state type and register layout of the block cipher engine
package aes_pkg;
    localparam logic [15:0] KEY_BASE = 16'h7c00;
    localparam logic [15:0] A_BASE = 16'h7c20;
    localparam logic [15:0] B_BASE = 16'h7c30;
    localparam logic [15:0] XOR_BASE = 16'h7c40;
    localparam logic [15:0] AREA_END = 16'h7c50;
    localparam int START_BIT = 11;
    localparam int OP_LSB = 9;
    localparam int LEN_LSB = 0;
    localparam logic [1:0] OP_ENC = 2'h0;
    localparam logic [1:0] OP_CHAIN = 2'h1;
    localparam logic [1:0] OP_DEC = 2'h2;
    localparam logic [1:0] OP_EXPAND = 2'h3;
    localparam logic [1:0] LEN_192 = 2'h1;
    localparam logic [1:0] LEN_256 = 2'h2;
    localparam logic [7:0] SBOX_AFFINE = 8'h63;
    localparam logic [7:0] ISBOX_AFFINE = 8'h05;
    localparam logic [7:0] GF_POLY = 8'h1b;

    typedef enum logic [1:0] {S_IDLE = 2'b01, S_RUN = 2'b10} phase_t;

    typedef struct packed {
        phase_t state;
        logic [1:0] op;
        logic [1:0] len;
        logic dec_dir;
        logic [3:0] nk;
        logic [3:0] nr;
        logic [3:0] p;
        logic [3:0] k;
        logic [5:0] e;
        logic [1:0] c;
        logic [3:0] n;
        logic [7:0][31:0] win;
        logic [127:0] rk;
        logic [127:0] st;
        logic [255:0] key;
        logic [127:0] ta;
        logic [127:0] tb;
        logic [7:0][31:0] dwin;
        logic [3:0] dp;
        logic [3:0] dk;
        logic dvalid;
        logic [7:0] rdata;
    } engine_t;
endpackage

// *** core/aes_engine.sv ***
// Iterative block cipher engine with on-the-fly key expansion and byte-mapped work areas
module aes_engine (
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    input wire logic I_MEM_WR,
    input wire logic I_MEM_RD,
    input wire logic [15:0] I_MEM_ADDR,
    input wire logic [7:0] I_MEM_WDATA,
    output logic [7:0] O_MEM_RDATA,
    input wire logic I_FIRST_CONTROL_WR,
    input wire logic [15:0] I_FIRST_CONTROL_DATA,
    input wire logic I_SECOND_CONTROL_WR,
    input wire logic [15:0] I_SECOND_CONTROL_DATA,
    output logic [15:0] O_FIRST_CONTROL_WORD,
    output logic [15:0] O_SECOND_CONTROL_WORD,
    output logic O_KEY_READY
);
    aes_pkg::engine_t r;
    aes_pkg::engine_t next_r;
    logic busy;
    logic go;
    logic [127:0] xor_result_buffer;

    function automatic logic [7:0] xt(input logic [7:0] a);
        return {a[6:0], 1'b0} ^ (a[7] ? aes_pkg::GF_POLY : 8'h00);
    endfunction

    function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++)
        begin
            if (b[i])
                p = p ^ x;
            x = xt(x);
        end
        return p;
    endfunction

    // Field inverse as a^254
    function automatic logic [7:0] ginv(input logic [7:0] a);
        logic [7:0] q;
        logic [7:0] y;
        q = a;
        y = 8'h01;
        for (int i = 0; i < 7; i++)
        begin
            q = gmul(q, q);
            y = gmul(y, q);
        end
        return y;
    endfunction

    function automatic logic [7:0] rl(input logic [7:0] a, input int s);
        return 8'((a << s) | (a >> (8 - s)));
    endfunction

    function automatic logic [7:0] sb(input logic [7:0] a, input logic inv);
        logic [7:0] b;
        b = ginv(a);
        if (inv)
            return ginv(rl(a, 1) ^ rl(a, 3) ^ rl(a, 6) ^ aes_pkg::ISBOX_AFFINE);
        return b ^ rl(b, 1) ^ rl(b, 2) ^ rl(b, 3) ^ rl(b, 4) ^ aes_pkg::SBOX_AFFINE;
    endfunction

    function automatic logic [31:0] subw(input logic [31:0] w);
        return {sb(w[31:24], 1'b0), sb(w[23:16], 1'b0), sb(w[15:8], 1'b0), sb(w[7:0], 1'b0)};
    endfunction

    function automatic logic [7:0] rcon(input logic [3:0] k);
        logic [7:0] v;
        v = 8'h01;
        for (int i = 1; i < 15; i++)
            if (i < int'(k))
                v = xt(v);
        return v;
    endfunction

    // Schedule transform of the previous word at a given phase
    function automatic logic [31:0] kt(input logic [31:0] x, input logic [3:0] ph,
                                       input logic [3:0] kk, input logic [3:0] nk);
        if (ph == 4'h0)
            return subw({x[23:0], x[31:24]}) ^ {rcon(kk), 24'h000000};
        if (nk == 4'h8 && ph == 4'h4)
            return subw(x);
        return x;
    endfunction

    // Column mix, forward or inverse
    function automatic logic [127:0] mixc(input logic [127:0] s, input logic inv);
        logic [127:0] o;
        logic [7:0] cf [4];
        o = '0;
        if (inv)
            cf = '{8'h0e, 8'h0b, 8'h0d, 8'h09};
        else
            cf = '{8'h02, 8'h03, 8'h01, 8'h01};
        for (int c = 0; c < 4; c++)
            for (int w = 0; w < 4; w++)
                for (int j = 0; j < 4; j++)
                    o[127 - 8 * (4 * c + w) -: 8] = o[127 - 8 * (4 * c + w) -: 8]
                        ^ gmul(cf[(j - w + 4) % 4], s[127 - 8 * (4 * c + j) -: 8]);
        return o;
    endfunction

    // Substitution, row shift and optional column mix
    function automatic logic [127:0] rnd(input logic [127:0] s, input logic inv,
                                         input logic mix);
        logic [127:0] t;
        int src;
        t = '0;
        src = 0;
        for (int c = 0; c < 4; c++)
            for (int w = 0; w < 4; w++)
            begin
                src = 4 * ((c + (inv ? 4 - w : w)) % 4) + w;
                t[127 - 8 * (4 * c + w) -: 8] = sb(s[127 - 8 * src -: 8], inv);
            end
        return mix ? mixc(t, inv) : t;
    endfunction

    assign busy = (r.state == aes_pkg::S_RUN);
    assign go = I_FIRST_CONTROL_WR && I_FIRST_CONTROL_DATA[aes_pkg::START_BIT] && !busy;
    assign xor_result_buffer = r.ta ^ r.tb;

    always_comb
    begin
        logic [31:0] word;
        logic [31:0] fresh;
        logic [3:0] pp;
        logic [3:0] kp;
        logic [127:0] rkf;
        logic [127:0] res;
        logic [1:0] op;
        logic [15:0] off;
        word = '0;
        fresh = '0;
        pp = '0;
        kp = '0;
        rkf = '0;
        res = '0;
        op = I_FIRST_CONTROL_DATA[aes_pkg::OP_LSB +: 2];
        off = I_MEM_ADDR - aes_pkg::KEY_BASE;
        next_r = r;
        if (I_SECOND_CONTROL_WR && !busy)
        begin
            next_r.len = I_SECOND_CONTROL_DATA[aes_pkg::LEN_LSB +: 2];
            if (next_r.len != r.len)
                next_r.dvalid = 1'b0;
        end
        if (I_FIRST_CONTROL_WR && !busy)
            next_r.op = op;
        // Key and area A are locked during a block; area B stays open for feedback flows
        if (I_MEM_WR && I_MEM_ADDR >= aes_pkg::KEY_BASE && I_MEM_ADDR < aes_pkg::A_BASE
            && !busy)
        begin
            next_r.key[255 - 8 * off[4:0] -: 8] = I_MEM_WDATA;
            next_r.dvalid = 1'b0;
        end
        if (I_MEM_WR && I_MEM_ADDR >= aes_pkg::A_BASE && I_MEM_ADDR < aes_pkg::B_BASE
            && !busy)
            next_r.ta[127 - 8 * off[3:0] -: 8] = I_MEM_WDATA;
        if (I_MEM_WR && I_MEM_ADDR >= aes_pkg::B_BASE && I_MEM_ADDR < aes_pkg::XOR_BASE)
            next_r.tb[127 - 8 * off[3:0] -: 8] = I_MEM_WDATA;
        next_r.rdata = 8'h00;
        if (I_MEM_RD && I_MEM_ADDR >= aes_pkg::KEY_BASE && I_MEM_ADDR < aes_pkg::A_BASE)
            next_r.rdata = r.key[255 - 8 * off[4:0] -: 8];
        else if (I_MEM_RD && I_MEM_ADDR >= aes_pkg::A_BASE && I_MEM_ADDR < aes_pkg::B_BASE)
            next_r.rdata = r.ta[127 - 8 * off[3:0] -: 8];
        else if (I_MEM_RD && I_MEM_ADDR >= aes_pkg::B_BASE && I_MEM_ADDR < aes_pkg::XOR_BASE)
            next_r.rdata = r.tb[127 - 8 * off[3:0] -: 8];
        else if (I_MEM_RD && I_MEM_ADDR >= aes_pkg::XOR_BASE && I_MEM_ADDR < aes_pkg::AREA_END)
            next_r.rdata = xor_result_buffer[127 - 8 * off[3:0] -: 8];
        case (r.state)
            aes_pkg::S_IDLE:
            begin
                if (go)
                begin
                    next_r.state = aes_pkg::S_RUN;
                    next_r.op = op;
                    // Key word count and round count per key size
                    next_r.nk = (r.len == aes_pkg::LEN_256) ? 4'h8 :
                                (r.len == aes_pkg::LEN_192) ? 4'h6 : 4'h4;
                    next_r.nr = (r.len == aes_pkg::LEN_256) ? 4'he :
                                (r.len == aes_pkg::LEN_192) ? 4'hc : 4'ha;
                    next_r.dec_dir = (op == aes_pkg::OP_DEC);
                    next_r.c = 2'h0;
                    next_r.n = 4'h0;
                    next_r.e = 6'h00;
                    for (int i = 0; i < 8; i++)
                        next_r.win[i] = r.key[255 - 32 * i -: 32];
                    next_r.p = 4'h0;
                    next_r.k = 4'h0;
                    if (op == aes_pkg::OP_DEC)
                    begin
                        next_r.win = r.dwin;
                        next_r.p = r.dp;
                        next_r.k = r.dk;
                    end
                    // Chained operation feeds the XOR buffer into the cipher
                    next_r.st = r.ta;
                    if (op == aes_pkg::OP_CHAIN)
                        next_r.st = xor_result_buffer;
                end
            end
            aes_pkg::S_RUN:
            begin
                next_r.e = r.e + 6'h01;
                next_r.c = r.c + 2'h1;
                if (!r.dec_dir)
                begin
                    if (r.e == 6'(4 * r.nr + 4 - r.nk))
                    begin
                        next_r.dwin = r.win;
                        next_r.dp = r.p;
                        next_r.dk = r.k;
                        next_r.dvalid = 1'b1;
                    end
                    word = r.win[0];
                    fresh = r.win[0] ^ kt(r.win[r.nk - 4'h1], r.p, r.k + 4'h1, r.nk);
                    for (int i = 0; i < 7; i++)
                        next_r.win[i] = r.win[i + 1];
                    next_r.win[r.nk - 4'h1] = fresh;
                    next_r.p = (r.p == r.nk - 4'h1) ? 4'h0 : r.p + 4'h1;
                    next_r.k = (r.p == r.nk - 4'h1) ? r.k + 4'h1 : r.k;
                    rkf = {r.rk[95:0], word};
                end
                else
                begin
                    pp = (r.p == 4'h0) ? r.nk - 4'h1 : r.p - 4'h1;
                    kp = (r.p == 4'h0) ? r.k - 4'h1 : r.k;
                    word = r.win[r.nk - 4'h1];
                    fresh = word ^ kt(r.win[r.nk - 4'h2], pp, kp + 4'h1, r.nk);
                    for (int i = 7; i > 0; i--)
                        next_r.win[i] = r.win[i - 1];
                    next_r.win[0] = fresh;
                    next_r.p = pp;
                    next_r.k = kp;
                    rkf = {word, r.rk[127:32]};
                end
                next_r.rk = rkf;
                if (r.c == 2'h3)
                begin
                    if (r.n == 4'h0)
                        res = r.st ^ rkf;
                    else if (!r.dec_dir)
                        res = rnd(r.st, 1'b0, r.n != r.nr) ^ rkf;
                    else if (r.n != r.nr)
                        res = mixc(rnd(r.st, 1'b1, 1'b0) ^ rkf, 1'b1);
                    else
                        res = rnd(r.st, 1'b1, 1'b0) ^ rkf;
                    next_r.st = res;
                    next_r.n = r.n + 4'h1;
                    if (r.n == r.nr)
                    begin
                        next_r.state = aes_pkg::S_IDLE;
                        if (r.op != aes_pkg::OP_EXPAND)
                            next_r.ta = res;
                    end
                end
            end
            default:
                next_r.state = aes_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge I_REF_CLK or posedge I_RST)
    begin
        if (I_RST)
            r <= '{state: aes_pkg::S_IDLE, default: '0};
        else
            r <= next_r;
    end

    assign O_MEM_RDATA = r.rdata;
    assign O_FIRST_CONTROL_WORD = {4'h0, busy, r.op, 9'h000};
    assign O_SECOND_CONTROL_WORD = {14'h0000, r.len};
    assign O_KEY_READY = r.dvalid;

    a_start_busy: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        go |=> busy ##1 busy)
        else $error("start did not raise busy");
    a_busy_ends: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        $rose(busy) |-> ##[44:60] !busy)
        else $error("block length out of range");
    a_word_count: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        $fell(busy) |-> r.e == 6'(4 * r.nr + 4))
        else $error("round count does not match key size");
    a_key_frozen: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        busy && $past(busy) |-> $stable(r.key) && $stable(r.op))
        else $error("key or operation changed mid block");
    a_expand_keeps: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        $fell(busy) && r.op == aes_pkg::OP_EXPAND |-> r.ta == $past(r.ta) && r.dvalid)
        else $error("expansion disturbed area A or left no key");
    a_chain_input: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        go && I_FIRST_CONTROL_DATA[10:9] == aes_pkg::OP_CHAIN |=> r.st == $past(xor_result_buffer))
        else $error("chained input not taken from XOR buffer");
    a_plain_input: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        go && I_FIRST_CONTROL_DATA[10:9] == aes_pkg::OP_ENC |=> r.st == $past(r.ta))
        else $error("encrypt input not taken from area A");
    a_result_area: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        $fell(busy) && r.op != aes_pkg::OP_EXPAND |-> r.ta == r.st)
        else $error("result not written to area A");
    a_key_drop: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        I_MEM_WR && !busy && I_MEM_ADDR >= aes_pkg::KEY_BASE
        && I_MEM_ADDR < aes_pkg::A_BASE |=> !r.dvalid)
        else $error("key write left stale final round key");
endmodule

// *** verif/host_model.sv ***
// Host-side model that moves bytes and control words into the cipher engine
module host_model (
    input wire logic i_clk,
    input wire logic i_busy,
    input wire logic [7:0] i_rdata,
    output logic o_wr,
    output logic o_rd,
    output logic [15:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_c1_wr,
    output logic [15:0] o_c1_data,
    output logic o_c2_wr,
    output logic [15:0] o_c2_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 16'h0000;
        o_wdata = 8'h00;
        o_c1_wr = 1'b0;
        o_c1_data = 16'h0000;
        o_c2_wr = 1'b0;
        o_c2_data = 16'h0000;
    end

    // Request held over one rising edge; released address and data show the inverse, not the old value; o_wr and o_rd drop to 0
    task automatic xfer(input logic wr, input logic rd, input logic [15:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        @(negedge i_clk);
        o_wr = wr;
        o_rd = rd;
        o_addr = a;
        o_wdata = d;
        @(negedge i_clk);
        q = i_rdata;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask

    task automatic ctrl(input logic second, input logic [15:0] d);
        @(negedge i_clk);
        o_c1_wr = !second;
        o_c2_wr = second;
        o_c1_data = d;
        o_c2_data = d;
        @(negedge i_clk);
        o_c1_wr = 1'b0;
        o_c2_wr = 1'b0;
        o_c1_data = ~d;
        o_c2_data = ~d;
    endtask

    task automatic load_key(input logic [1:0] len, input int n);
        logic [7:0] q;
        for (int t = 0; t < 300 && i_busy !== 1'b0; t++)
            @(negedge i_clk);
        ctrl(1'b1, {14'h0000, len});
        for (int i = 0; i < n; i++)
            xfer(1'b1, 1'b0, aes_pkg::KEY_BASE + 16'(i), 8'(i), q);
    endtask

    // Whole 16-byte blocks only; any padding is the host's job
    task automatic put_block(input logic [15:0] base, input logic [127:0] v);
        logic [7:0] q;
        for (int i = 0; i < 16; i++)
            xfer(1'b1, 1'b0, base + 16'(i), v[127 - 8 * i -: 8], q);
    endtask

    task automatic get_block(input logic [15:0] base, output logic [127:0] v);
        logic [7:0] q;
        for (int i = 0; i < 16; i++)
        begin
            xfer(1'b0, 1'b1, base + 16'(i), 8'h00, q);
            v[127 - 8 * i -: 8] = q;
        end
    endtask
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the block cipher engine
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [127:0] PT = 128'h00112233445566778899aabbccddeeff;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr, rd, c1_wr, c2_wr, key_ready;
    logic [15:0] addr, c1_data, c2_data, w1, w2;
    logic [7:0] wdata, rdata, q;
    logic [127:0] blk;
    logic [127:0] ct [3] = '{128'h69c4e0d86a7b0430d8cdb78070b4c55a,
        128'hdda97ca4864cdfe06eaf70a0ec0d7191, 128'h8ea2b7ca516745bfeafc49904b496089};
    logic [1:0] lens [3] = '{2'h0, aes_pkg::LEN_192, aes_pkg::LEN_256};
    int n_errors = 0;
    int n_tests = 0;
    int cyc;

    always #2 clk = ~clk;

    aes_engine DUT (.I_REF_CLK(clk), .I_RST(rst), .I_MEM_WR(wr), .I_MEM_RD(rd),
        .I_MEM_ADDR(addr), .I_MEM_WDATA(wdata), .O_MEM_RDATA(rdata),
        .I_FIRST_CONTROL_WR(c1_wr), .I_FIRST_CONTROL_DATA(c1_data),
        .I_SECOND_CONTROL_WR(c2_wr), .I_SECOND_CONTROL_DATA(c2_data),
        .O_FIRST_CONTROL_WORD(w1), .O_SECOND_CONTROL_WORD(w2), .O_KEY_READY(key_ready));

    host_model host (.i_clk(clk), .i_busy(w1[11]), .i_rdata(rdata), .o_wr(wr), .o_rd(rd),
        .o_addr(addr), .o_wdata(wdata), .o_c1_wr(c1_wr), .o_c1_data(c1_data),
        .o_c2_wr(c2_wr), .o_c2_data(c2_data));

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        if (n_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Counts the falling edges at which busy is seen high
    task automatic wait_idle;
        cyc = 0;
        while (w1[11] === 1'b1 && cyc < 300)
        begin
            cyc++;
            @(negedge clk);
        end
        if (cyc >= 300)
            n_errors++;
    endtask

    task automatic run(input logic [1:0] op);
        host.ctrl(1'b0, {4'h0, 1'b1, op, 9'h000});
        wait_idle();
        check(w1[10:9], op);
    endtask

    initial
    begin
        #100us;
        n_errors++;
        give_verdict();
    end

    initial
    begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        check({w1, w2, 7'h00, key_ready}, 40'h0);
        host.xfer(1'b1, 1'b0, aes_pkg::AREA_END, 8'h5a, q);
        host.xfer(1'b0, 1'b1, aes_pkg::AREA_END, 8'h00, q);
        check(q, 8'h00);
        for (int l = 0; l < 3; l++)
        begin
            host.load_key(lens[l], 16 + 8 * l);
            check(w2, {14'h0000, lens[l]});
            check(key_ready, 1'b0);
            host.put_block(aes_pkg::A_BASE, PT);
            run(aes_pkg::OP_ENC);
            check(cyc, 44 + 8 * l);
            host.get_block(aes_pkg::A_BASE, blk);
            check(blk, ct[l]);
            check(key_ready, 1'b1);
            run(aes_pkg::OP_DEC);
            host.get_block(aes_pkg::A_BASE, blk);
            check(blk, PT);
            run(aes_pkg::OP_ENC);
            host.get_block(aes_pkg::A_BASE, blk);
            check(blk, ct[l]);
        end
        host.ctrl(1'b0, {4'h0, 1'b1, aes_pkg::OP_DEC, 9'h000});
        host.xfer(1'b1, 1'b0, aes_pkg::A_BASE, 8'hff, q);
        host.ctrl(1'b1, 16'h0000);
        host.ctrl(1'b0, {4'h0, 1'b1, aes_pkg::OP_ENC, 9'h000});
        wait_idle();
        check(cyc > 0 && cyc < 60, 1'b1);
        check(w1[10:9], aes_pkg::OP_DEC);
        host.get_block(aes_pkg::A_BASE, blk);
        check(blk, PT);
        check(w2, {14'h0000, aes_pkg::LEN_256});
        host.xfer(1'b1, 1'b0, aes_pkg::KEY_BASE, 8'h00, q);
        check(key_ready, 1'b0);
        host.put_block(aes_pkg::A_BASE, ct[2]);
        run(aes_pkg::OP_EXPAND);
        check(cyc, 60);
        check(key_ready, 1'b1);
        host.get_block(aes_pkg::A_BASE, blk);
        check(blk, ct[2]);
        run(aes_pkg::OP_DEC);
        host.get_block(aes_pkg::A_BASE, blk);
        check(blk, PT);
        host.load_key(lens[0], 16);
        host.put_block(aes_pkg::A_BASE, 128'h0);
        host.put_block(aes_pkg::B_BASE, PT);
        host.get_block(aes_pkg::XOR_BASE, blk);
        check(blk, PT);
        run(aes_pkg::OP_CHAIN);
        host.get_block(aes_pkg::A_BASE, blk);
        check(blk, ct[0]);
        host.get_block(aes_pkg::XOR_BASE, blk);
        check(blk, ct[0] ^ PT);
        host.put_block(aes_pkg::B_BASE, ct[0] ^ PT);
        run(aes_pkg::OP_CHAIN);
        host.get_block(aes_pkg::A_BASE, blk);
        check(blk, ct[0]);
        give_verdict();
    end
endmodule
